//--- verilog/smeb_pkg.sv
// constants, types and states shared by the serial master and its testbench
// What this block does
// - select hold and divider 1 with idle between same-slave words keeps transmit-ready low.
// - with select hold, a word carrying the final-transfer bit releases select at drain.
// - fixed select with dma feed takes transfer size from select-zero word length.
// - divider 1 with odd word length 9, 11, 13 or 15 adds one serial clock pulse.
// - polarity 1, inverted phase 0, slow-divider transfer then divider-1 transfer adds a pulse.
// - no mixed-divider extra pulse when every select uses divider 1.
package smeb_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_CS = 4;
  localparam int CS_W = 2;
  localparam int DATA_W = 16;
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_LVL_W = 3;
  localparam int FINAL_BIT = 24;
  localparam int PCS_LSB = 16;

  // ****************************************
  // counts, codes and reset values
  // ****************************************
  localparam logic [2:0] FIFO_FULL_LVL = 3'h4;
  localparam logic [4:0] LEN_BASE = 5'h08;
  localparam logic [4:0] LEN_FULL = 5'h10;
  localparam logic [3:0] CODE_MAX = 4'h8;
  localparam logic [7:0] DIV_ONE = 8'h01;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [5:0] EDGE_RST = 6'h00;
  localparam logic [5:0] EDGE_EXTRA = 6'h02;
  localparam logic [3:0] SEL_IDLE = 4'hF;
  localparam logic [15:0] SHREG_RST = 16'h0000;
  localparam logic DRAINED_RST = 1'b1;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic hold;
    logic cpol;
    logic inverted_phase_bit;
    logic [3:0] bits_code;
    logic [7:0] divider;
  } smeb_cfg_t;

  typedef struct packed {
    logic [6:0] rsvd_hi;
    logic final_flag;
    logic [3:0] rsvd_mid;
    logic [3:0] pcs;
    logic [15:0] data;
  } smeb_word_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_SHIFT = 2'b10,
    ST_DONE = 2'b11
  } smeb_state_t;

endpackage

//--- verilog/smeb_fifo.sv
// word queue between the transmit port and the shifter
`timescale 1ns/10ps
module smeb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [LW-1:0] next_level;
  logic push;
  logic pop;

  assign in_ready = (level != LW'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // ****************************************
  // storage entries
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      logic [WIDTH-1:0] next_mem;
      always_comb begin
        next_mem = (push && (wr_ptr == PW'(i))) ? in_data : mem[i];
      end
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          mem[i] <= '0;
        end else begin
          mem[i] <= next_mem;
        end
      end
    end
  endgenerate

  // ****************************************
  // pointers and level
  // ****************************************
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    next_level = level + LW'(push) - LW'(pop);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
    end
  end

endmodule // smeb_fifo

//--- verilog/smeb_master.sv
// serial master: word queue, select control, clock divider and shifter
`timescale 1ns/10ps
module smeb_master (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic master_select_bit,
  input wire logic fixed_select_mode,
  input wire logic [1:0] fixed_select,
  input wire logic dma_feed,
  input wire smeb_pkg::smeb_cfg_t [3:0] select_cfg,
  input wire logic word_valid,
  input wire smeb_pkg::smeb_word_t word,
  output logic transmit_ready,
  output logic serial_clock_pin,
  output logic serial_data_out,
  output logic [3:0] select_n,
  output logic transmitter_drained_flag,
  output logic dma_halfword
);

  // ****************************************
  // state
  // ****************************************
  smeb_pkg::smeb_state_t state, next_state;
  smeb_pkg::smeb_cfg_t cur_cfg, next_cur_cfg;
  logic [7:0] phase_cnt, next_phase_cnt;
  logic [5:0] edge_cnt, next_edge_cnt;
  logic [5:0] edge_total, next_edge_total;
  logic [15:0] shreg, next_shreg;
  logic [1:0] cur_cs, next_cur_cs;
  logic [1:0] last_cs, next_last_cs;
  logic cur_final, next_cur_final;
  logic last_div_not_one, next_last_div_not_one;
  logic idle_seen, next_idle_seen;
  logic cs_held, next_cs_held;
  logic lost_ready, next_lost_ready;
  logic next_transmit_ready;
  logic next_serial_clock_pin;
  logic next_serial_data_out;
  logic [3:0] next_select_n;
  logic next_drained;
  logic next_dma_halfword;

  // ****************************************
  // queue
  // ****************************************
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [smeb_pkg::FIFO_LVL_W-1:0] fifo_level;
  logic [smeb_pkg::FIFO_LVL_W-1:0] next_level;
  smeb_pkg::smeb_word_t fifo_word;
  logic push;
  logic pop;

  assign push = word_valid & transmit_ready & fifo_in_ready;
  assign fifo_out_ready = (state == smeb_pkg::ST_IDLE) & master_select_bit;
  assign pop = fifo_out_valid & fifo_out_ready;

  smeb_fifo #(
    .WIDTH(smeb_pkg::WORD_W),
    .DEPTH(smeb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_word),
    .level(fifo_level)
  );

  // ****************************************
  // word being loaded
  // ****************************************
  logic [1:0] load_cs;
  smeb_pkg::smeb_cfg_t load_cfg;
  logic [3:0] load_code;
  logic [4:0] load_len;
  logic load_div1;
  logic load_ex5;
  logic load_ex6;
  logic [7:0] cur_div_eff;
  logic cur_div1;
  logic [4:0] cur_len;
  logic shift_now;
  logic cfg0_wide;
  logic sel_wide;

  always_comb begin
    load_cs = fixed_select_mode ? fixed_select : fifo_word.pcs[smeb_pkg::CS_W-1:0];
    load_cfg = select_cfg[load_cs];
    load_code = (load_cfg.bits_code > smeb_pkg::CODE_MAX) ? smeb_pkg::CODE_MAX : load_cfg.bits_code;
    load_len = smeb_pkg::LEN_BASE + {1'b0, load_code};
    load_div1 = (load_cfg.divider <= smeb_pkg::DIV_ONE);
    load_ex5 = load_div1 & load_len[0];
    load_ex6 = load_div1 & load_cfg.cpol & ~load_cfg.inverted_phase_bit & last_div_not_one;
    cur_div_eff = (cur_cfg.divider == 8'h00) ? smeb_pkg::DIV_ONE : cur_cfg.divider;
    cur_div1 = (cur_div_eff == smeb_pkg::DIV_ONE);
    cur_len = smeb_pkg::LEN_BASE + {1'b0, (cur_cfg.bits_code > smeb_pkg::CODE_MAX) ?
      smeb_pkg::CODE_MAX : cur_cfg.bits_code};
    shift_now = cur_cfg.inverted_phase_bit ? edge_cnt[0] : (~edge_cnt[0] && (edge_cnt != smeb_pkg::EDGE_RST));
    cfg0_wide = (select_cfg[0].bits_code != 4'h0);
    sel_wide = (select_cfg[fixed_select_mode ? fixed_select : cur_cs].bits_code != 4'h0);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    next_cur_cfg = cur_cfg;
    next_phase_cnt = phase_cnt;
    next_edge_cnt = edge_cnt;
    next_edge_total = edge_total;
    next_shreg = shreg;
    next_cur_cs = cur_cs;
    next_last_cs = last_cs;
    next_cur_final = cur_final;
    next_last_div_not_one = last_div_not_one;
    next_idle_seen = idle_seen;
    next_cs_held = cs_held;
    next_lost_ready = lost_ready;
    next_serial_clock_pin = serial_clock_pin;
    next_serial_data_out = serial_data_out;
    next_select_n = select_n;
    next_drained = transmitter_drained_flag;
    case (state)
      smeb_pkg::ST_IDLE: begin
        next_serial_clock_pin = master_select_bit ? cur_cfg.cpol : 1'b0;
        if (cs_held && !pop) begin
          next_idle_seen = 1'b1;
        end
        if (pop) begin
          next_cur_cfg = load_cfg;
          next_cur_cs = load_cs;
          next_cur_final = fifo_word.final_flag;
          next_select_n = smeb_pkg::SEL_IDLE & ~(4'h1 << load_cs);
          next_lost_ready = load_cfg.hold & load_div1 & cs_held & idle_seen & (load_cs == last_cs);
          next_drained = 1'b0;
          next_shreg = fifo_word.data << (smeb_pkg::LEN_FULL - load_len);
          next_serial_data_out = next_shreg[15];
          next_serial_clock_pin = load_cfg.cpol;
          next_phase_cnt = smeb_pkg::PHASE_RST;
          next_edge_cnt = smeb_pkg::EDGE_RST;
          next_edge_total = {load_len, 1'b0} + (load_ex5 ? smeb_pkg::EDGE_EXTRA : smeb_pkg::EDGE_RST)
            + (load_ex6 ? smeb_pkg::EDGE_EXTRA : smeb_pkg::EDGE_RST);
          next_state = smeb_pkg::ST_SETUP;
        end
      end
      smeb_pkg::ST_SETUP: begin
        next_state = smeb_pkg::ST_SHIFT;
      end
      smeb_pkg::ST_SHIFT: begin
        if (phase_cnt == cur_div_eff - smeb_pkg::DIV_ONE) begin
          next_phase_cnt = smeb_pkg::PHASE_RST;
          next_serial_clock_pin = ~serial_clock_pin;
          next_edge_cnt = edge_cnt + 6'h01;
          if (shift_now) begin
            next_shreg = {shreg[14:0], 1'b0};
            next_serial_data_out = shreg[14];
          end
          if (edge_cnt + 6'h01 == edge_total) begin
            next_state = smeb_pkg::ST_DONE;
          end
        end else begin
          next_phase_cnt = phase_cnt + 8'h01;
        end
      end
      smeb_pkg::ST_DONE: begin
        next_drained = 1'b1;
        next_last_cs = cur_cs;
        next_last_div_not_one = ~cur_div1;
        next_idle_seen = 1'b0;
        next_lost_ready = 1'b0;
        if (cur_final || !cur_cfg.hold) begin
          next_select_n = smeb_pkg::SEL_IDLE;
          next_cs_held = 1'b0;
        end else begin
          next_cs_held = 1'b1;
        end
        next_state = smeb_pkg::ST_IDLE;
      end
      default: begin
        next_state = smeb_pkg::ST_IDLE;
      end
    endcase
    next_level = fifo_level + {2'b00, push} - {2'b00, pop};
    next_transmit_ready = (next_level != smeb_pkg::FIFO_FULL_LVL) & ~next_lost_ready;
    next_dma_halfword = (dma_feed && fixed_select_mode) ? cfg0_wide : sel_wide;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= smeb_pkg::ST_IDLE;
      cur_cfg <= '0;
      phase_cnt <= smeb_pkg::PHASE_RST;
      edge_cnt <= smeb_pkg::EDGE_RST;
      edge_total <= smeb_pkg::EDGE_RST;
      shreg <= smeb_pkg::SHREG_RST;
      cur_cs <= 2'h0;
      last_cs <= 2'h0;
      cur_final <= 1'b0;
      last_div_not_one <= 1'b0;
      idle_seen <= 1'b0;
      cs_held <= 1'b0;
      lost_ready <= 1'b0;
      transmit_ready <= 1'b0;
      serial_clock_pin <= 1'b0;
      serial_data_out <= 1'b0;
      select_n <= smeb_pkg::SEL_IDLE;
      transmitter_drained_flag <= smeb_pkg::DRAINED_RST;
      dma_halfword <= 1'b0;
    end else begin
      state <= next_state;
      cur_cfg <= next_cur_cfg;
      phase_cnt <= next_phase_cnt;
      edge_cnt <= next_edge_cnt;
      edge_total <= next_edge_total;
      shreg <= next_shreg;
      cur_cs <= next_cur_cs;
      last_cs <= next_last_cs;
      cur_final <= next_cur_final;
      last_div_not_one <= next_last_div_not_one;
      idle_seen <= next_idle_seen;
      cs_held <= next_cs_held;
      lost_ready <= next_lost_ready;
      transmit_ready <= next_transmit_ready;
      serial_clock_pin <= next_serial_clock_pin;
      serial_data_out <= next_serial_data_out;
      select_n <= next_select_n;
      transmitter_drained_flag <= next_drained;
      dma_halfword <= next_dma_halfword;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [5:0] pulse_cnt;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pulse_cnt <= smeb_pkg::EDGE_RST;
    end else if (state == smeb_pkg::ST_SETUP) begin
      pulse_cnt <= smeb_pkg::EDGE_RST;
    end else if (state == smeb_pkg::ST_SHIFT && next_serial_clock_pin != serial_clock_pin) begin
      pulse_cnt <= pulse_cnt + 6'h01;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence seq_load;
    (state == smeb_pkg::ST_IDLE && pop) ##1 (state == smeb_pkg::ST_SETUP);
  endsequence

  sequence seq_finish;
    (state == smeb_pkg::ST_SHIFT) ##1 (state == smeb_pkg::ST_DONE);
  endsequence

  a_ready_lost_low: assert property (lost_ready |-> !transmit_ready)
    else $error("transmit ready high while lost");
  a_final_release: assert property (seq_finish ##0 (cur_final || !cur_cfg.hold)
    |=> (select_n == smeb_pkg::SEL_IDLE) && transmitter_drained_flag)
    else $error("select not released at drain");
  a_hold_keeps_select: assert property ((state == smeb_pkg::ST_DONE && !cur_final && cur_cfg.hold)
    |=> select_n != smeb_pkg::SEL_IDLE)
    else $error("held select dropped");
  a_clock_before_master: assert property ((state == smeb_pkg::ST_IDLE && !master_select_bit && !pop)
    |=> !serial_clock_pin)
    else $error("clock pin moved before master select");
  a_dma_size_zero: assert property ((dma_feed && fixed_select_mode) |=> dma_halfword == $past(cfg0_wide))
    else $error("dma size not from select zero");
  a_odd_extra_pulse: assert property (seq_load ##0 (cur_div1 && cur_len[0] && !last_div_not_one)
    |-> edge_total == {cur_len, 1'b0} + smeb_pkg::EDGE_EXTRA)
    else $error("odd length pulse count wrong");
  a_mixed_div_pulse: assert property (seq_load ##0 (cur_div1 && !cur_len[0] && cur_cfg.cpol
    && !cur_cfg.inverted_phase_bit && last_div_not_one) |-> edge_total == {cur_len, 1'b0} + smeb_pkg::EDGE_EXTRA)
    else $error("mixed divider pulse missing");
  a_all_div_one: assert property (seq_load ##0 (!last_div_not_one && !(cur_div1 && cur_len[0]))
    |-> edge_total == {cur_len, 1'b0})
    else $error("unexpected extra pulse");
  a_select_in_xfer: assert property ((state == smeb_pkg::ST_SHIFT) |-> !select_n[cur_cs])
    else $error("select inactive while shifting");
  a_pulse_count: assert property (seq_finish |-> pulse_cnt == edge_total)
    else $error("serial clock pulse count wrong");

  // ****************************************
  // queue and load checks
  // ****************************************
  a_full_not_ready: assert property ((fifo_level == smeb_pkg::FIFO_FULL_LVL) |-> !transmit_ready)
    else $error("transmit ready high with full queue");
  a_lost_clears: assert property (seq_finish |=> !lost_ready)
    else $error("lost ready kept after transfer");
  a_load_select: assert property (seq_load |-> (select_n == (smeb_pkg::SEL_IDLE & ~(4'h1 << cur_cs)))
    && !transmitter_drained_flag)
    else $error("select or drained wrong at load");
  a_setup_to_shift: assert property (seq_load |=> state == smeb_pkg::ST_SHIFT)
    else $error("shift did not follow setup");
  a_dma_size_sel: assert property (!(dma_feed && fixed_select_mode) |=> dma_halfword == $past(sel_wide))
    else $error("dma size not from addressed select");

endmodule // smeb_master

//--- verification/smeb_slave.sv
// behavioural serial slave: counts clock edges and captures bits of each transfer
`timescale 1ns/10ps
module smeb_slave (
  input wire logic clk_sys,
  input wire logic sck,
  input wire logic sdo,
  input wire logic [3:0] sel_n,
  input wire logic busy,
  input wire logic cpol,
  input wire logic inverted_phase_bit,
  output logic [5:0] edges,
  output logic [15:0] captured,
  output logic [3:0] sel_seen
);
  logic prev_sck = 1'b0;
  logic prev_busy = 1'b0;
  // ****************************************
  // capture on the edge chosen by phase
  // ****************************************
  always @(posedge clk_sys) begin
    prev_sck <= sck;
    prev_busy <= busy;
    if (busy && !prev_busy) begin
      edges <= 6'h00;
      captured <= 16'h0000;
    end else if (sck != prev_sck) begin
      edges <= edges + 6'h01;
      sel_seen <= sel_n;
      if ((sck != cpol) == inverted_phase_bit) begin
        captured <= {captured[14:0], sdo};
      end
    end
  end
endmodule // smeb_slave

//--- verification/smeb_master_tb.sv
// self-checking bench for the serial master with a slave model
`timescale 1ns/10ps
module smeb_master_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic ms = 1'b0;
  logic fm = 1'b0;
  logic [1:0] fs = 2'h0;
  logic dma = 1'b0;
  smeb_pkg::smeb_cfg_t [3:0] cfg = '0;
  logic wv = 1'b0;
  smeb_pkg::smeb_word_t w = '0;
  logic tr, sck, sdo, drained, half;
  logic [3:0] sel_n;
  logic [3:0] seen;
  logic [5:0] edges;
  logic [15:0] cap;
  logic cpol = 1'b0;
  logic inverted_phase_bit = 1'b1;
  logic [7:0] pd = 8'h01;
  logic [31:0] seed = 32'hA5F1;
  int err_count = 0;
  int checks = 0;

  smeb_master i_smeb_master (
    .clk_sys(clk_sys), .resetn(resetn), .master_select_bit(ms), .fixed_select_mode(fm),
    .fixed_select(fs), .dma_feed(dma), .select_cfg(cfg), .word_valid(wv), .word(w),
    .transmit_ready(tr), .serial_clock_pin(sck), .serial_data_out(sdo), .select_n(sel_n),
    .transmitter_drained_flag(drained), .dma_halfword(half)
  );
  smeb_slave i_smeb_slave (
    .clk_sys(clk_sys), .sck(sck), .sdo(sdo), .sel_n(sel_n), .busy(!drained),
    .cpol(cpol), .inverted_phase_bit(inverted_phase_bit), .edges(edges), .captured(cap), .sel_seen(seen)
  );

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [4:0] len(input logic [3:0] c);
    return (c > 4'h8) ? 5'h10 : 5'h08 + {1'b0, c};
  endfunction
  function automatic logic [5:0] extra(input logic [1:0] s);
    logic [5:0] x;
    x = 6'h00;
    if (cfg[s].divider <= 8'h01 && (len(cfg[s].bits_code) & 5'h01) == 5'h01) x = x + 6'h02;
    if (cfg[s].divider <= 8'h01 && cfg[s].cpol && !cfg[s].inverted_phase_bit && pd > 8'h01) x = x + 6'h02;
    return x;
  endfunction
  function automatic logic exp_half(input logic [1:0] s, input logic d);
    return (d ? cfg[0].bits_code : cfg[s].bits_code) != 4'h0;
  endfunction
  task automatic send(input logic [3:0] p, input logic [15:0] d, input logic f);
    logic t;
    int k;
    k = 0;
    w = '{7'h00, f, 4'h0, p, d};
    wv = 1'b1;
    do begin
      t = tr;
      cyc(1);
      k++;
    end while (t !== 1'b1 && k < 2000);
    if (t !== 1'b1) chk("taken", 1, 0);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    while (drained !== 1'b0 && k < 50) begin
      cyc(1);
      k++;
    end
    while (drained !== 1'b1 && k < 3000) begin
      cyc(1);
      k++;
    end
    if (k >= 3000) chk("done", 1, 0);
  endtask
  task automatic frame(input logic [1:0] s, input logic [15:0] d);
    logic [5:0] x;
    logic [15:0] m;
    x = extra(s);
    m = 16'hFFFF >> (5'h10 - len(cfg[s].bits_code));
    cpol = cfg[s].cpol;
    inverted_phase_bit = cfg[s].inverted_phase_bit;
    send({2'h0, s}, d, 1'b0);
    wv = 1'b0;
    wait_done();
    pd = cfg[s].divider;
    chk("edges", {len(cfg[s].bits_code), 1'b0} + x, edges);
    chk("select", 4'(~(4'h1 << s)), seen);
    if (x == 6'h00) chk("data", d & m, cap & m);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    #2000000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    ms = 1'b1;
    cyc(2);
    chk("ready", 1, tr);
    for (int c = 0; c < 9; c++) begin
      cfg[0] = '{1'b0, 1'b0, 1'b1, c[3:0], 8'h01};
      frame(2'h0, 16'h5A3C + c[15:0]);
    end
    for (int i = 0; i < 12; i++) begin
      nxt();
      cfg[seed[1:0]] = '{1'b0, 1'b0, 1'b1, seed[5:2] % 4'h9, 8'h01 + {6'h00, seed[7:6] % 2'h3}};
      frame(seed[1:0], seed[23:8]);
    end
    $display("test lengths done");
    for (int i = 0; i < 4; i++) cfg[i] = '{1'b0, 1'b1, 1'b0, 4'h0, 8'h02};
    cfg[1].divider = 8'h01;
    frame(2'h0, 16'h00A5);
    frame(2'h1, 16'h005A);
    for (int i = 0; i < 4; i++) cfg[i].divider = 8'h01;
    frame(2'h0, 16'h00C3);
    frame(2'h1, 16'h003C);
    $display("test mixed dividers done");
    fm = 1'b1;
    for (int i = 0; i < 8; i++) begin
      nxt();
      fs = seed[1:0];
      dma = seed[2];
      for (int k = 0; k < 4; k++) cfg[k].bits_code = seed[4*k+3 +: 4] % 4'h9;
      cyc(2);
      chk("halfword", exp_half(fs, dma), half);
    end
    fs = 2'h1;
    dma = 1'b1;
    cfg[0].bits_code = 4'h2;
    cfg[1].bits_code = 4'h0;
    cyc(2);
    chk("halfword", 1, half);
    cfg[0].bits_code = 4'h0;
    cfg[1].bits_code = 4'h4;
    cyc(2);
    chk("halfword", 0, half);
    $display("test transfer size done");
    fs = 2'h2;
    cfg[2] = '{1'b1, 1'b0, 1'b1, 4'h0, 8'h02};
    cpol = 1'b0;
    inverted_phase_bit = 1'b1;
    send(4'h0, 16'h0011, 1'b1);
    wv = 1'b0;
    wait_done();
    chk("release", 4'hF, sel_n);
    send(4'h0, 16'h0022, 1'b0);
    wv = 1'b0;
    wait_done();
    chk("hold", 4'hB, sel_n);
    cfg[2].divider = 8'h01;
    cyc(3);
    send(4'h0, 16'h0033, 1'b0);
    wv = 1'b0;
    cyc(4);
    chk("ready", 0, tr);
    wait_done();
    send(4'h0, 16'h0044, 1'b1);
    wv = 1'b0;
    wait_done();
    chk("release", 4'hF, sel_n);
    $display("test select hold done");
    ms = 1'b0;
    fm = 1'b0;
    cfg[0] = '{1'b0, 1'b0, 1'b1, 4'h0, 8'h01};
    for (int i = 0; i < 4; i++) send(4'h0, 16'h0050 + i[15:0], 1'b0);
    wv = 1'b0;
    cyc(2);
    chk("full", 0, tr);
    w.data = 16'h00EE;
    wv = 1'b1;
    cyc(3);
    wv = 1'b0;
    chk("idle clock", 0, sck);
    ms = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wait_done();
      chk("queue", 16'h0050 + i, {8'h00, cap[7:0]});
    end
    cyc(40);
    chk("refused", 1, drained);
    $display("test queue done");
    summarize();
  end
endmodule // smeb_master_tb
